// File: shared/dma_chan_defs.svh
`ifndef DMA_CHAN_DEFS_SVH
`define DMA_CHAN_DEFS_SVH
// Register byte addresses
`define OFS_SRC_SEL   12'h000
`define OFS_CTRL      12'h004
`define OFS_SRC_ADDR  12'h008
`define OFS_DST_ADDR  12'h00C
`define OFS_COUNT     12'h010
`define OFS_INT_CTRL  12'h014
`define OFS_SER_STAT  12'h018
// Source select fields
`define SEL_LO        0
`define SEL_HI        3
`define SEL_EXT_BIT   6
`define SEL_SW_BIT    7
`define SEL_RD_MASK   32'h000000CF
// Source codes for the serial events
`define SEL_CODE_TX   4'h1
`define SEL_CODE_RX   4'h2
// Channel control fields
`define CTL_UNIT_BIT  0
`define CTL_RPT_BIT   1
`define CTL_REQ_BIT   2
`define CTL_EN_BIT    3
`define CTL_SDIR_BIT  4
`define CTL_DDIR_BIT  5
`define CTL_RD_MASK   32'h0000003F
// Address and counter widths
`define ADDR_MASK     32'h000FFFFF
`define CNT_MASK      32'h0000FFFF
// Interrupt control fields
`define ILVL_LO       0
`define ILVL_HI       2
`define IR_BIT        3
`endif

// File: shared/dma_chan_pkg.sv
package dma_chan_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WRITE
   } xfer_state_t;
endpackage : dma_chan_pkg

// File: logic/uart_dma_channel.sv
`timescale 1ns/10ps
`include "dma_chan_defs.svh"

module uart_dma_channel
   import dma_chan_pkg::*;
#(
   parameter int          ADDR_W     = 20,
   parameter int          CNT_W      = 16,
   parameter int          NUM_SER    = 3,
   parameter logic        CHANNEL_ID = 1'b0,
   parameter logic [3:0]  SER_ONE    = 4'h1
) (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   // APB slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // Serial channel status, one bit per channel
   input  wire logic [NUM_SER-1:0]  tx_empty_in,
   input  wire logic [NUM_SER-1:0]  rx_done_in,
   // Memory bus master
   output logic                     mem_rd,
   output logic                     mem_wr,
   output logic      [ADDR_W-1:0]   mem_addr,
   output logic      [7:0]          mem_wdata,
   input  wire logic [7:0]          mem_rdata,
   input  wire logic                mem_ack,
   // Interrupt toward the processor
   output logic                     irq_req,
   output logic      [2:0]          irq_level
);

   typedef struct packed {
      logic [NUM_SER-1:0] tx_s1;
      logic [NUM_SER-1:0] tx_s2;
      logic [NUM_SER-1:0] tx_prev;
      logic [NUM_SER-1:0] rx_s1;
      logic [NUM_SER-1:0] rx_s2;
      logic [NUM_SER-1:0] rx_prev;
      logic [3:0]         src_sel;
      logic               ext_sel;
      logic               sw_req;
      logic               unit_sel;
      logic               rpt_sel;
      logic               req_flag;
      logic               enable;
      logic               src_dir;
      logic               dst_dir;
      logic [ADDR_W-1:0]  src_addr;
      logic [ADDR_W-1:0]  dst_addr;
      logic [CNT_W-1:0]   count;
      logic [CNT_W-1:0]   reload;
      logic [2:0]         ilvl;
      logic               ir;
      xfer_state_t        state;
      logic [7:0]         data;
      logic               mem_rd;
      logic               mem_wr;
      logic [ADDR_W-1:0]  mem_addr;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               irq_req;
      logic [2:0]         irq_level;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Event decode for the transfer trigger; status readback uses the synced flags

   function automatic logic event_hit(input logic [3:0] sel,
                                      input logic [NUM_SER-1:0] tx_rise,
                                      input logic [NUM_SER-1:0] rx_rise);
      logic [3:0] idx;
      logic       hit;
      idx = sel - 4'h1;
      hit = 1'b0;
      for (int i = 0; i < NUM_SER; i++) begin
         if (sel == 4'(2 * i) + `SEL_CODE_TX) begin
            if (!(4'(i) == SER_ONE && CHANNEL_ID != 1'b0)) begin
               hit = tx_rise[i];
            end
         end else if (sel == 4'(2 * i) + `SEL_CODE_RX) begin
            if (!(4'(i) == SER_ONE && CHANNEL_ID != 1'b1)) begin
               hit = rx_rise[i];
            end
         end
      end
      if (idx == 4'hF) begin
         hit = 1'b0;
      end
      return hit;
   endfunction : event_hit

   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                              input logic dir,
                                              input logic unit);
      logic [ADDR_W-1:0] inc;
      inc = unit ? ADDR_W'(1) : ADDR_W'(2);
      return dir ? a + inc : a;
   endfunction : step

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [NUM_SER-1:0] tx_rise;
      logic [NUM_SER-1:0] rx_rise;
      logic               trig;
      logic               wr_acc;
      logic               rd_acc;
      logic               last;
      tx_rise = '0;
      rx_rise = '0;
      trig    = 1'b0;
      wr_acc  = 1'b0;
      rd_acc  = 1'b0;
      last    = 1'b0;
      st_nxt  = st_r;

      st_nxt.tx_s1   = tx_empty_in;
      st_nxt.tx_s2   = st_r.tx_s1;
      st_nxt.tx_prev = st_r.tx_s2;
      st_nxt.rx_s1   = rx_done_in;
      st_nxt.rx_s2   = st_r.rx_s1;
      st_nxt.rx_prev = st_r.rx_s2;
      tx_rise = st_r.tx_s2 & ~st_r.tx_prev;
      rx_rise = st_r.rx_s2 & ~st_r.rx_prev;

      trig = event_hit(st_r.src_sel, tx_rise, rx_rise) | st_r.sw_req;
      st_nxt.sw_req = 1'b0;

      // APB answers in the access cycle with a one-cycle pready; a write
      // lands only at the edge where the master samples pready high
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         st_nxt.pready = 1'b1;
         rd_acc = !pwrite;
         if (paddr > `OFS_SER_STAT ||
             (pwrite && paddr == `OFS_SER_STAT)) begin
            st_nxt.pslverr = 1'b1;
         end
      end
      wr_acc = psel && penable && pwrite && st_r.pready;

      // request flag, set wins over a software clear
      if (wr_acc && paddr == `OFS_CTRL) begin
         st_nxt.unit_sel = pwdata[`CTL_UNIT_BIT];
         st_nxt.rpt_sel  = pwdata[`CTL_RPT_BIT];
         st_nxt.req_flag = pwdata[`CTL_REQ_BIT];
         st_nxt.enable   = pwdata[`CTL_EN_BIT];
         st_nxt.src_dir  = pwdata[`CTL_SDIR_BIT];
         st_nxt.dst_dir  = pwdata[`CTL_DDIR_BIT];
      end else if (wr_acc && paddr == `OFS_SRC_SEL) begin
         st_nxt.src_sel = pwdata[`SEL_HI:`SEL_LO];
         st_nxt.ext_sel = pwdata[`SEL_EXT_BIT];
         st_nxt.sw_req  = pwdata[`SEL_SW_BIT];
      end else if (wr_acc && paddr == `OFS_SRC_ADDR) begin
         st_nxt.src_addr = pwdata[ADDR_W-1:0];
      end else if (wr_acc && paddr == `OFS_DST_ADDR) begin
         st_nxt.dst_addr = pwdata[ADDR_W-1:0];
      end else if (wr_acc && paddr == `OFS_COUNT) begin
         st_nxt.count  = pwdata[CNT_W-1:0];
         st_nxt.reload = pwdata[CNT_W-1:0];
      end else if (wr_acc && paddr == `OFS_INT_CTRL) begin
         st_nxt.ilvl = pwdata[`ILVL_HI:`ILVL_LO];
         st_nxt.ir   = st_r.ir & pwdata[`IR_BIT];
      end

      // hardware raises request, set beats clear
      if (trig && st_r.enable) begin
         st_nxt.req_flag = 1'b1;
      end

      case (st_r.state)
         ST_IDLE: begin
            if (st_r.enable && st_r.req_flag) begin
               st_nxt.req_flag = trig;
               st_nxt.state    = ST_READ;
               st_nxt.mem_rd   = 1'b1;
               st_nxt.mem_addr = st_r.src_addr;
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               st_nxt.data     = mem_rdata;
               st_nxt.mem_rd   = 1'b0;
               st_nxt.mem_wr   = 1'b1;
               st_nxt.mem_addr = st_r.dst_addr;
               st_nxt.state    = ST_WRITE;
            end
         end
         ST_WRITE: begin
            if (mem_ack) begin
               st_nxt.mem_wr = 1'b0;
               st_nxt.state  = ST_IDLE;
               st_nxt.src_addr = step(st_r.src_addr, st_r.src_dir,
                                      st_r.unit_sel);
               st_nxt.dst_addr = step(st_r.dst_addr, st_r.dst_dir,
                                      st_r.unit_sel);
               last = (st_r.count == '0);
               st_nxt.count = st_r.count - CNT_W'(1);
               if (last) begin
                  st_nxt.ir = 1'b1;
                  if (!st_r.rpt_sel) begin
                     st_nxt.enable = 1'b0;
                  end else begin
                     st_nxt.count = st_r.reload;
                  end
               end
            end
         end
         default: st_nxt.state = ST_IDLE;
      endcase

      st_nxt.prdata = '0;
      if (rd_acc) begin
         if (paddr == `OFS_SRC_SEL) begin
            st_nxt.prdata = 32'({st_r.sw_req, st_r.ext_sel, 2'b00,
                                 st_r.src_sel}) & `SEL_RD_MASK;
         end else if (paddr == `OFS_CTRL) begin
            st_nxt.prdata = 32'({st_r.dst_dir, st_r.src_dir, st_r.enable,
                                 st_r.req_flag, st_r.rpt_sel,
                                 st_r.unit_sel}) & `CTL_RD_MASK;
         end else if (paddr == `OFS_SRC_ADDR) begin
            st_nxt.prdata = 32'(st_r.src_addr) & `ADDR_MASK;
         end else if (paddr == `OFS_DST_ADDR) begin
            st_nxt.prdata = 32'(st_r.dst_addr) & `ADDR_MASK;
         end else if (paddr == `OFS_COUNT) begin
            st_nxt.prdata = 32'(st_r.count) & `CNT_MASK;
         end else if (paddr == `OFS_INT_CTRL) begin
            st_nxt.prdata = 32'({st_r.ir, st_r.ilvl});
         end else if (paddr == `OFS_SER_STAT) begin
            st_nxt.prdata = 32'({st_r.rx_s2, st_r.tx_s2});
         end
      end

      // level zero keeps the request from the processor
      st_nxt.irq_level = st_nxt.ilvl;
      st_nxt.irq_req   = st_nxt.ir && (st_nxt.ilvl != 3'h0);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r       <= '0;
         st_r.state <= ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata    = st_r.prdata;
   assign pready    = st_r.pready;
   assign pslverr   = st_r.pslverr;
   assign mem_rd    = st_r.mem_rd;
   assign mem_wr    = st_r.mem_wr;
   assign mem_addr  = st_r.mem_addr;
   assign mem_wdata = st_r.data;
   assign irq_req   = st_r.irq_req;
   assign irq_level = st_r.irq_level;

endmodule : uart_dma_channel

// File: bench/mem_model.sv
`timescale 1ns/10ps
module mem_model #(parameter int ADDR_W = 20) (
   // Channel requests
   input  wire logic              sys_clk,
   input  wire logic [3:0]        dly,
   input  wire logic              mem_rd,
   input  wire logic              mem_wr,
   input  wire logic [ADDR_W-1:0] mem_addr,
   // Answer
   output logic      [7:0]        mem_rdata,
   output logic                   mem_ack
);
   int n = 0;
   initial begin
      mem_rdata = 8'hA5;
      mem_ack   = 1'b0;
   end
   // Data toggles when not acked so stale bytes never look valid
   always @(posedge sys_clk) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if ((mem_rd || mem_wr) && !mem_ack) begin
         n = n + 1;
         if (n > dly) begin
            n = 0;
            mem_ack   <= 1'b1;
            mem_rdata <= mem_addr[7:0] ^ 8'h5A;
         end
      end
   end
endmodule : mem_model

// File: bench/uart_dma_channel_chk.sv
`timescale 1ns/10ps
module uart_dma_channel_chk #(parameter int ADDR_W = 20) (
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              reset_n,
   // Register bus
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [11:0]       paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   // Memory side
   input wire logic              mem_rd,
   input wire logic              mem_wr,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0]        mem_wdata,
   input wire logic [7:0]        mem_rdata,
   input wire logic              mem_ack,
   // Interrupt
   input wire logic              irq_req,
   input wire logic [2:0]        irq_level
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   AST_APB_ONE: assert property (
      psel && !penable |=> pready ##1 !pready) else $error("bad answer");
   AST_BAD_ADDR: assert property (
      psel && !penable && paddr > 12'h018 |=> pslverr) else $error("no err");
   AST_IRQ_GATE: assert property (
      irq_req |-> irq_level != 3'h0) else $error("irq at level zero");
   AST_ONE_PHASE: assert property (
      !(mem_rd && mem_wr)) else $error("read and write together");
   AST_RD_HOLD: assert property (
      mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr)) else $error("rd");
   AST_WR_HOLD: assert property (
      mem_wr && !mem_ack |=> mem_wr && $stable(mem_addr)) else $error("wr");
   AST_RD_TO_WR: assert property (
      mem_rd && mem_ack |=> mem_wr && mem_wdata == $past(mem_rdata))
      else $error("write byte differs from read byte");
   AST_WR_END: assert property (
      mem_wr && mem_ack |=> !mem_wr) else $error("write not ended");
   cover property (mem_wr && mem_ack);
   cover property (irq_req);
   cover property (pslverr);
   cover property (mem_rd && mem_ack);
endmodule : uart_dma_channel_chk

bind uart_dma_channel uart_dma_channel_chk #(.ADDR_W(ADDR_W)) chk_u (
   .sys_clk, .reset_n, .psel, .penable, .paddr, .pready, .pslverr,
   .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
   .irq_req, .irq_level);

// File: bench/uart_dma_channel_tb.sv
`timescale 1ns/10ps
`include "dma_chan_defs.svh"
module uart_dma_channel_tb;
   logic sys_clk = '0, reset_n = '0, psel = '0, penable = '0, pwrite = '0;
   logic pready, pslverr, mem_rd, mem_wr, mem_ack, irq_req, err_bit;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [2:0]  tx_empty_in = 3'h0, rx_done_in = 3'h0, irq_level;
   logic [19:0] mem_addr, ra, wa;
   logic [7:0]  mem_wdata, mem_rdata, wd;
   logic [3:0]  dly = 4'h0;
   int          err_count = 0, tests_run = 0, nw = 0;
   logic [31:0] wv [6] = '{32'hFFFFFF7F, 32'hFFFFFFF3, '1, '1, '1, '1};
   logic [31:0] rv [6] = '{32'h4F, 32'h33, 32'hFFFFF, 32'hFFFFF,
                           32'hFFFF, 32'h7};
   uart_dma_channel dut_u (
      .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .tx_empty_in, .rx_done_in, .mem_rd,
      .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .irq_req,
      .irq_level);
   mem_model mem_u (
      .sys_clk, .dly, .mem_rd, .mem_wr, .mem_addr, .mem_rdata, .mem_ack);
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (mem_ack && mem_rd)
         ra <= mem_addr;
      if (mem_ack && mem_wr) begin
         wa <= mem_addr;
         wd <= mem_wdata;
         nw <= nw + 1;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int i;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 16 && pready !== 1'b1; i++)
         @(posedge sys_clk);
      if (i == 16) begin
         err_count++;
         end_of_test();
      end
      q = prdata;
      err_bit = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   task automatic cfg(input logic [31:0] sel, ctl, src, dst, cnt, lvl);
      wr(`OFS_SRC_SEL, sel);
      wr(`OFS_SRC_ADDR, src);
      wr(`OFS_DST_ADDR, dst);
      wr(`OFS_COUNT, cnt);
      wr(`OFS_INT_CTRL, lvl);
      wr(`OFS_CTRL, ctl);
   endtask : cfg
   // Raise one serial flag, expect n transfers, then drop it
   task automatic ev(input logic rx, input int s, input int n);
      int i;
      int k;
      k = nw;
      if (rx)
         rx_done_in[s] <= 1'b1;
      else
         tx_empty_in[s] <= 1'b1;
      for (i = 0; i < 40 && nw == k; i++)
         @(posedge sys_clk);
      chk(32'(nw - k), 32'(n));
      rd(`OFS_SER_STAT, rx ? 32'h8 << s : 32'h1 << s);
      rx_done_in  <= 3'h0;
      tx_empty_in <= 3'h0;
      repeat (4) @(posedge sys_clk);
   endtask : ev
   task automatic end_of_test();
      $display("mismatches %0d of %0d checks", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      for (int a = 0; a < 28; a += 4)
         rd(12'(a), 32'h0);
      for (int j = 0; j < 6; j++) begin
         wr(12'(4 * j), wv[j]);
         rd(12'(4 * j), rv[j]);
      end
      apb(1'b0, 12'h01C, 32'h0);
      chk(32'(err_bit), 32'h1);
      apb(1'b1, `OFS_SER_STAT, 32'h0);
      chk(32'(err_bit), 32'h1);
      cfg(32'h1, 32'h19, 32'h12345, 32'hABC, 32'h1, 32'h5);
      ev(1'b0, 0, 1);
      chk(32'(ra), 32'h12345);
      chk(32'(wa), 32'h00ABC);
      chk(32'(wd), 32'h45 ^ 32'h5A);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_CTRL, 32'h19);
      ev(1'b0, 0, 1);
      chk(32'(ra), 32'h12346);
      chk(32'(wa), 32'h00ABC);
      rd(`OFS_CTRL, 32'h11);
      rd(`OFS_INT_CTRL, 32'hD);
      chk(32'(irq_req), 32'h1);
      chk(32'(irq_level), 32'h5);
      wr(`OFS_INT_CTRL, 32'h5);
      rd(`OFS_INT_CTRL, 32'h5);
      chk(32'(irq_req), 32'h0);
      ev(1'b0, 0, 0);
      // Slow memory, fixed source, destination steps by two
      dly <= 4'h3;
      cfg(32'h6, 32'h28, 32'h100, 32'h200, 32'h1, 32'h0);
      ev(1'b1, 2, 1);
      ev(1'b1, 2, 1);
      chk(32'(ra), 32'h00100);
      chk(32'(wa), 32'h00202);
      rd(`OFS_INT_CTRL, 32'h8);
      chk(32'(irq_req), 32'h0);
      cfg(32'h4, 32'h9, 32'h0, 32'h0, 32'h0, 32'h1);
      ev(1'b1, 1, 0);
      // Software request; repeat mode reloads the count and stays enabled
      cfg(32'h0, 32'h1B, 32'h300, 32'h400, 32'h0, 32'h2);
      wr(`OFS_SRC_SEL, 32'h80);
      ev(1'b0, 2, 1);
      chk(32'(ra), 32'h00300);
      chk(32'(wa), 32'h00400);
      rd(`OFS_SRC_SEL, 32'h0);
      rd(`OFS_CTRL, 32'h1B);
      rd(`OFS_COUNT, 32'h0);
      rd(`OFS_SRC_ADDR, 32'h301);
      rd(`OFS_INT_CTRL, 32'hA);
      chk(32'(irq_level), 32'h2);
      chk(32'(irq_req), 32'h1);
      end_of_test();
   end
endmodule : uart_dma_channel_tb
